// >>> logic/pulse_to_stroke_controller.sv
// pulse-to-stroke controller: contact scaling, batch, memory, calibration, aux, flow stop
// assumes apb master on pclk; contact, aux, monitor and feedback inputs are asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module pulse_to_stroke_controller
    import stroke_ctrl_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    input wire logic pclk,            // system clock 100 MHz
    input wire logic presetn,         // async reset, active low
    input wire logic psel,            // apb select
    input wire logic penable,         // apb enable
    input wire logic pwrite,          // apb write
    input wire logic [7:0] paddr,     // apb byte address
    input wire logic [31:0] pwdata,   // apb write data
    output logic [31:0] prdata,       // apb read data
    output logic pready,              // apb ready
    output logic pslverr,             // apb error on unmapped address
    input wire logic contact_in,      // external contact pulse pin
    input wire logic aux_in,          // auxiliary rate select pin
    input wire logic monitor_present, // dosing monitor detect pin
    input wire logic monitor_fb,      // dosing monitor stroke report pin
    input wire logic [7:0] stroke_len,// stroke length knob in scale divisions
    output logic stroke_out,          // one-cycle drive stroke pulse
    output logic fault_out,           // fault state
    output logic warn_lamp,           // yellow warning lamp
    output logic calib_flash,         // flash display and calib indicator
    output logic aux_ind,             // auxiliary indicator
    output logic mem_ind              // memory extension indicator
);
    // ==========================================================
    // synchronisers: first stage feeds only the second
    logic [3:0] sync1_reg, sync2_reg;
    logic contact_d_reg, fb_d_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
            contact_d_reg <= 1'b0;
            fb_d_reg <= 1'b0;
        end else begin
            sync1_reg <= {monitor_fb, monitor_present, aux_in, contact_in};
            sync2_reg <= sync1_reg;
            contact_d_reg <= sync2_reg[0];
            fb_d_reg <= sync2_reg[3];
        end
    end
    wire contact_s = sync2_reg[0];
    wire aux_s = sync2_reg[1];
    wire mon_s = sync2_reg[2];
    wire fb_s = sync2_reg[3];
    wire fb_rise = fb_s & ~fb_d_reg;

    // ==========================================================
    // registers
    logic [1:0] mode_reg;
    logic mem_reg, run_reg, qty_reg;
    logic [1:0] press_reg, size_reg;
    logic [13:0] factor_reg;
    logic [15:0] batch_reg, rate_reg, aux_rate_reg;
    logic [7:0] flow_reg, cal_len_reg;
    logic cal_valid_reg, cal_run_reg, fault_reg;
    logic [15:0] pending_reg;
    logic [13:0] accum_reg;
    logic [31:0] total_reg, volume_reg, cal_cnt_reg;
    logic [7:0] miss_reg;
    logic await_fb_reg;
    logic [31:0] prdata_reg;

    // ==========================================================
    // apb decode; single-cycle answer, writes take effect in access phase
    wire acc = psel & penable;
    wire wr = acc & pwrite;
    wire sel_ctrl = (paddr == OFS_CTRL);
    wire sel_fac = (paddr == OFS_FACTOR);
    wire sel_bat = (paddr == OFS_BATCH);
    wire sel_rate = (paddr == OFS_RATE);
    wire sel_aux = (paddr == OFS_AUX);
    wire sel_flow = (paddr == OFS_FLOW);
    wire sel_cal = (paddr == OFS_CALIB);
    wire sel_cmd = (paddr == OFS_CMD);
    wire mapped = sel_ctrl | sel_fac | sel_bat | sel_rate | sel_aux | sel_flow | sel_cal
        | sel_cmd | (paddr == OFS_STATUS) | (paddr == OFS_PENDING) | (paddr == OFS_TOTAL)
        | (paddr == OFS_VOLUME) | (paddr == OFS_CALCNT);
    assign pready = 1'b1;
    assign pslverr = acc & ~mapped;
    assign prdata = prdata_reg;

    wire [1:0] new_mode = pwdata[CTRL_MODE_LSB +: 2];
    wire mode_chg = wr & sel_ctrl & (new_mode != mode_reg);
    wire cmd_w = wr & sel_cmd;
    wire pkey = cmd_w & pwdata[CMD_PKEY];
    wire info = cmd_w & pwdata[CMD_INFO];
    wire cal_start = cmd_w & pwdata[CMD_CAL_START];
    wire cal_stop = cmd_w & pwdata[CMD_CAL_STOP];
    wire ack = cmd_w & pwdata[CMD_ACK];
    wire clr = cmd_w & pwdata[CMD_CLEAR];

    // pressure level allowed by liquid end class 0..2 (3 means no adjustment)
    function automatic logic [1:0] press_limit(input logic [1:0] sz, input logic [1:0] req);
        logic [1:0] top;
        top = (sz == 2'd0) ? 2'd3 : (sz == 2'd1) ? 2'd2 : 2'd1;
        if (sz == 2'd3) press_limit = 2'd0;
        else press_limit = (req > top) ? top : req;
    endfunction

    // factor accepted only in range, hundredths; batch takes integers only
    wire fac_ok = (pwdata[13:0] >= FACTOR_MIN) && (pwdata[13:0] <= FACTOR_MAX)
        && (pwdata[31:14] == 18'h0);
    wire bat_ok = (pwdata[15:0] != 16'h0) && (pwdata[31:16] == 16'h0);

    // configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= 2'd0;
            mem_reg <= 1'b0;
            qty_reg <= 1'b0;
            press_reg <= 2'd3;
            size_reg <= 2'd0;
            factor_reg <= FACTOR_ONE;
            batch_reg <= BATCH_RST;
            rate_reg <= RATE_RST;
            aux_rate_reg <= RATE_RST;
            flow_reg <= FLOW_RST;
        end else begin
            if (wr & sel_ctrl) begin
                mode_reg <= new_mode;
                mem_reg <= pwdata[CTRL_MEM_BIT];
                qty_reg <= pwdata[CTRL_QTY_BIT];
                size_reg <= pwdata[CTRL_SIZE_LSB +: 2];
                press_reg <= press_limit(pwdata[CTRL_SIZE_LSB +: 2],
                    pwdata[CTRL_PRESS_LSB +: 2]);
            end else if (info && mode_reg == 2'(MODE_BATCH)) begin
                qty_reg <= ~qty_reg;
            end
            if (mode_chg) factor_reg <= FACTOR_ONE;
            else if (wr & sel_fac & fac_ok) factor_reg <= pwdata[13:0];
            if (wr & sel_bat & bat_ok) batch_reg <= pwdata[15:0];
            if (wr & sel_rate) rate_reg <= pwdata[15:0];
            if (wr & sel_aux) aux_rate_reg <= pwdata[15:0];
            if (wr & sel_flow & mon_s) flow_reg <= pwdata[7:0];
        end
    end

    // ==========================================================
    // stroke rate generator: tick divider then rate period counter
    logic [15:0] tdiv_reg, per_reg;
    wire tick = (tdiv_reg == 16'(TICK_CYCLES - 1));
    wire [15:0] rate_sel = aux_s ? aux_rate_reg : rate_reg;
    wire rate_zero = (rate_sel == 16'h0);
    wire slot = tick & (per_reg >= rate_sel - 16'h1) & ~rate_zero;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tdiv_reg <= 16'h0;
            per_reg <= 16'h0;
        end else begin
            tdiv_reg <= tick ? 16'h0 : tdiv_reg + 16'h1;
            if (slot) per_reg <= 16'h0;
            else if (tick) per_reg <= per_reg + 16'h1;
        end
    end

    // ==========================================================
    // pulse scaling: accum holds hundredths, overflow of 100 gives a stroke
    wire pulse = contact_s & ~contact_d_reg & ~fault_reg;
    wire is_contact = (mode_reg == 2'(MODE_CONTACT));
    wire is_batch = (mode_reg == 2'(MODE_BATCH));
    wire is_manual = (mode_reg == 2'(MODE_MANUAL));
    wire [14:0] acc_sum = {1'b0, accum_reg} + {1'b0, factor_reg};
    wire [6:0] whole = 7'(acc_sum / 15'd100);
    wire [13:0] rem = 14'(acc_sum % 15'd100);
    wire trig = is_batch & (pulse | pkey);
    wire [16:0] add_c = {1'b0, pending_reg} + 17'(whole);
    wire [16:0] add_b = {1'b0, pending_reg} + {1'b0, batch_reg};
    wire [16:0] cap = mem_reg ? {1'b0, MEM_MAX} : {1'b0, batch_reg};
    wire fire = slot & (pending_reg != 16'h0) & ~fault_reg & run_reg & ~cal_run_reg
        & (is_contact | is_batch);
    wire cal_fire = slot & cal_run_reg & ~fault_reg;
    wire man_fire = slot & is_manual & run_reg & ~cal_run_reg & ~fault_reg;
    wire stroke_now = fire | cal_fire | man_fire;
    // without memory only strokes fitting one pulse are kept in contact mode
    wire [16:0] keep_c = mem_reg ? add_c : 17'(whole) + (fire ? 17'h1 : 17'h0);
    wire ovf_c = is_contact & pulse & mem_reg & (add_c > {1'b0, MEM_MAX});

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending_reg <= 16'h0;
            accum_reg <= 14'h0;
        end else if (mode_chg) begin
            pending_reg <= 16'h0;
            accum_reg <= 14'h0;
        end else if (is_contact & pulse & ~ovf_c) begin
            accum_reg <= rem;
            pending_reg <= 16'(keep_c - (fire ? 17'h1 : 17'h0));
        end else if (trig) begin
            pending_reg <= 16'(((add_b > cap) ? cap : add_b) - (fire ? 17'h1 : 17'h0));
        end else if (fire) begin
            pending_reg <= pending_reg - 16'h1;
        end
    end

    // ==========================================================
    // dosing monitor: a stroke without feedback before the next one counts as missed
    wire miss_hit = mon_s & stroke_now & await_fb_reg;
    wire flow_stop = miss_hit & (miss_reg + 8'h1 >= flow_reg) & (flow_reg != 8'h0);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            miss_reg <= 8'h0;
            await_fb_reg <= 1'b0;
        end else begin
            if (fb_rise) miss_reg <= 8'h0;
            else if (miss_hit) miss_reg <= miss_reg + 8'h1;
            if (stroke_now) await_fb_reg <= 1'b1;
            else if (fb_rise) await_fb_reg <= 1'b0;
        end
    end

    // ==========================================================
    // run, fault and calibration state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_reg <= 1'b1;
            fault_reg <= 1'b0;
            cal_run_reg <= 1'b0;
            cal_valid_reg <= 1'b0;
            cal_len_reg <= 8'h0;
        end else begin
            // new fault wins over an acknowledge in the same cycle
            if (ovf_c) fault_reg <= 1'b1;
            else if (ack) fault_reg <= 1'b0;
            if (flow_stop | (cal_run_reg & cal_stop)) run_reg <= 1'b0;
            else if (wr & sel_ctrl) run_reg <= pwdata[CTRL_RUN_BIT];
            if (cal_start & ~cal_run_reg) cal_run_reg <= 1'b1;
            else if (cal_stop | flow_stop) cal_run_reg <= 1'b0;
            if (cal_run_reg & cal_stop) begin
                cal_valid_reg <= 1'b1;
                cal_len_reg <= stroke_len;
            end
        end
    end

    // counters: total strokes, volume, calibration strokes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            total_reg <= 32'h0;
            volume_reg <= 32'h0;
            cal_cnt_reg <= 32'h0;
        end else begin
            if ((cal_run_reg & cal_stop) | clr) begin
                total_reg <= 32'h0;
                volume_reg <= 32'h0;
            end else if (stroke_now) begin
                total_reg <= total_reg + 32'h1;
                volume_reg <= volume_reg + 32'(stroke_len);
            end
            if (cal_start & ~cal_run_reg) cal_cnt_reg <= 32'h0;
            else if (cal_fire) cal_cnt_reg <= cal_cnt_reg + 32'h1;
            if (wr & sel_cal) cal_cnt_reg <= pwdata;
        end
    end

    // calibration drift check in scale divisions
    wire [7:0] len_diff = (stroke_len > cal_len_reg) ? stroke_len - cal_len_reg
        : cal_len_reg - stroke_len;
    wire drift = cal_valid_reg & (len_diff > CAL_SPAN);

    // ==========================================================
    // outputs and read mux
    wire [31:0] ctrl_rd = {18'h0, size_reg, 2'h0, press_reg, 3'h0, qty_reg, run_reg,
        mem_reg, mode_reg};
    wire [31:0] stat_rd = {24'h0, miss_reg[1:0], mon_s, aux_s, drift, cal_valid_reg,
        cal_run_reg, fault_reg};
    wire [31:0] rd_mux = sel_ctrl ? ctrl_rd
        : sel_fac ? {18'h0, factor_reg}
        : sel_bat ? {16'h0, batch_reg}
        : sel_rate ? {16'h0, rate_reg}
        : sel_aux ? {16'h0, aux_rate_reg}
        : sel_flow ? (mon_s ? {24'h0, flow_reg} : 32'h0)
        : sel_cal ? cal_cnt_reg
        : (paddr == OFS_STATUS) ? stat_rd
        : (paddr == OFS_PENDING) ? {16'h0, pending_reg}
        : (paddr == OFS_TOTAL) ? total_reg
        : (paddr == OFS_VOLUME) ? volume_reg
        : (paddr == OFS_CALCNT) ? cal_cnt_reg
        : 32'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0;
            stroke_out <= 1'b0;
            fault_out <= 1'b0;
            warn_lamp <= 1'b0;
            calib_flash <= 1'b0;
            aux_ind <= 1'b0;
            mem_ind <= 1'b0;
        end else begin
            if (psel & ~penable & ~pwrite) prdata_reg <= rd_mux;
            stroke_out <= stroke_now;
            fault_out <= fault_reg;
            warn_lamp <= drift;
            calib_flash <= drift;
            aux_ind <= aux_s;
            mem_ind <= mem_reg;
        end
    end
endmodule
`default_nettype wire

// >>> logic/stroke_ctrl_pkg.sv
// shared constants for the pulse-to-stroke controller
// assumes a single pclk domain and an apb master on the register side
package stroke_ctrl_pkg;
    // ==========================================================
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FACTOR = 8'h04;
    localparam logic [7:0] OFS_BATCH = 8'h08;
    localparam logic [7:0] OFS_RATE = 8'h0C;
    localparam logic [7:0] OFS_AUX = 8'h10;
    localparam logic [7:0] OFS_FLOW = 8'h14;
    localparam logic [7:0] OFS_CALIB = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_PENDING = 8'h20;
    localparam logic [7:0] OFS_TOTAL = 8'h24;
    localparam logic [7:0] OFS_VOLUME = 8'h28;
    localparam logic [7:0] OFS_CALCNT = 8'h2C;
    localparam logic [7:0] OFS_CMD = 8'h30;
    // ==========================================================
    // control register fields
    localparam int CTRL_MODE_LSB = 0;   // 2 bits
    localparam int CTRL_MEM_BIT = 2;
    localparam int CTRL_RUN_BIT = 3;
    localparam int CTRL_QTY_BIT = 4;    // batch entry: 0 strokes, 1 quantity
    localparam int CTRL_PRESS_LSB = 8;  // 2 bits
    localparam int CTRL_SIZE_LSB = 12;  // 2 bits liquid end class
    // command register bits (write one pulses)
    localparam int CMD_PKEY = 0;
    localparam int CMD_INFO = 1;
    localparam int CMD_CAL_START = 2;
    localparam int CMD_CAL_STOP = 3;
    localparam int CMD_ACK = 4;
    localparam int CMD_CLEAR = 5;
    // ==========================================================
    // reset values and limits
    localparam logic [13:0] FACTOR_ONE = 14'd100;  // hundredths
    localparam logic [13:0] FACTOR_MIN = 14'd1;
    localparam logic [13:0] FACTOR_MAX = 14'd9999;
    localparam logic [15:0] MEM_MAX = 16'hFFFF;
    localparam logic [15:0] BATCH_RST = 16'h0001;
    localparam logic [15:0] RATE_RST = 16'h0064;
    localparam logic [7:0] FLOW_RST = 8'h03;
    localparam logic [7:0] CAL_SPAN = 8'd10;       // scale divisions
    localparam int CLK_HZ = 100_000_000;
    localparam int TICK_US = 10;                    // rate step period
    localparam int TICK_CYC = (CLK_HZ / 1_000_000) * TICK_US;

    typedef enum logic [1:0] {MODE_MANUAL, MODE_ANALOG, MODE_CONTACT, MODE_BATCH} mode_t;
    typedef enum logic [1:0] {PRESS_4, PRESS_7, PRESS_10, PRESS_16} press_t;
endpackage

// >>> bench/stroke_ctrl_assertions.sv
// port checker for the pulse-to-stroke controller
// assumes a zero-wait apb slave and one pclk domain
`timescale 1ns/1ps
`default_nettype none
module stroke_ctrl_checker (
    input wire logic pclk,          // clock
    input wire logic presetn,       // reset, active low
    input wire logic psel,          // apb select
    input wire logic penable,       // apb enable
    input wire logic pwrite,        // apb write
    input wire logic [7:0] paddr,   // apb address
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready,        // apb ready
    input wire logic pslverr,       // apb error
    input wire logic aux_in,        // aux pin
    input wire logic stroke_out,    // stroke pulse
    input wire logic fault_out,     // fault level
    input wire logic warn_lamp,     // warning lamp
    input wire logic calib_flash,   // calibration flash
    input wire logic aux_ind        // aux indicator
);
    // ==========================================================
    // relations; aux passes a synchroniser, so five steady cycles are allowed
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence aux_held; aux_in [*5]; endsequence
    sequence aux_gone; !aux_in [*5]; endsequence
    sequence rd_access; psel && penable && !pwrite; endsequence
    ready_always_a: assert property (pready) else $error("pready low");
    err_unmapped_a: assert property (psel && penable && paddr > 8'h30 |-> pslverr)
        else $error("no error on unmapped access");
    err_mapped_a: assert property (psel && penable && paddr <= 8'h30 && paddr[1:0] == 2'h0
        |-> !pslverr) else $error("error on mapped access");
    err_access_a: assert property (pslverr |-> psel && penable) else $error("stray error");
    read_hold_a: assert property (rd_access |=> $stable(prdata)) else $error("read data moved");
    stroke_pulse_a: assert property (stroke_out |=> !stroke_out) else $error("long stroke");
    fault_quiet_a: assert property (fault_out && $past(fault_out) |-> !stroke_out)
        else $error("stroke in fault");
    aux_on_a: assert property (aux_held |-> aux_ind) else $error("aux indicator off");
    aux_off_a: assert property (aux_gone |-> !aux_ind) else $error("aux indicator on");
    flash_warn_a: assert property (calib_flash |-> warn_lamp) else $error("flash without lamp");
endmodule
bind pulse_to_stroke_controller stroke_ctrl_checker u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .aux_in(aux_in), .stroke_out(stroke_out),
    .fault_out(fault_out), .warn_lamp(warn_lamp), .calib_flash(calib_flash), .aux_ind(aux_ind));
`default_nettype wire

// >>> bench/contact_source.sv
// contact pulse source and dosing monitor model
// assumes pulse() is called just after a rising pclk edge
`timescale 1ns/1ps
`default_nettype none
module contact_source (
    input wire logic pclk,       // clock
    input wire logic stroke_out, // stroke pulse from the pump
    input wire logic echo_en,    // monitor answers strokes when high
    output logic contact_in,     // contact pulse pin
    output logic monitor_fb      // monitor report pin
);
    initial contact_in = 1'b0;
    initial monitor_fb = 1'b0;
    // ==========================================================
    // every stroke is reported one cycle later; a dead monitor stays low
    always @(posedge pclk) monitor_fb <= echo_en && stroke_out;
    // pulse long enough for a two-flop synchroniser, then a quiet gap
    task automatic pulse();
        contact_in <= 1'b1;
        repeat (4) @(posedge pclk);
        contact_in <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// >>> bench/tb_pulse_to_stroke_controller.sv
// self-checking bench for the pulse-to-stroke controller
// assumes TICK_CYCLES of 2 and rate 1, so a stroke slot comes every 2 cycles
`timescale 1ns/1ps
`default_nettype none
module tb_pulse_to_stroke_controller;
    import stroke_ctrl_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, aux_in, monitor_present, echo_en, err;
    logic [7:0] paddr, stroke_len;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, contact_in, monitor_fb, stroke_out, fault_out, warn_lamp;
    logic calib_flash, aux_ind, mem_ind;
    int error_cnt = 0, total_checks = 0, strokes = 0, base = 0, cyc = 0;
    int tbl [5][3] = '{'{75, 4, 3}, '{250, 2, 5}, '{10, 10, 1}, '{2500, 1, 25}, '{1, 100, 1}};
    pulse_to_stroke_controller #(.TICK_CYCLES(2)) u_pulse_to_stroke_controller (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .contact_in(contact_in), .aux_in(aux_in), .monitor_present(monitor_present),
        .monitor_fb(monitor_fb), .stroke_len(stroke_len), .stroke_out(stroke_out),
        .fault_out(fault_out), .warn_lamp(warn_lamp), .calib_flash(calib_flash),
        .aux_ind(aux_ind), .mem_ind(mem_ind));
    contact_source u_contact_source (.pclk(pclk), .stroke_out(stroke_out), .echo_en(echo_en),
        .contact_in(contact_in), .monitor_fb(monitor_fb));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // ==========================================================
    // stroke tally and hang guard, ceiling well above the planned run
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (stroke_out === 1'b1) strokes <= strokes + 1;
        if (cyc == 60000) begin
            error_cnt++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_bit(input string n, input logic e, input logic g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %b seen %b", n, e, g);
        end
    endtask
    // ==========================================================
    // apb master: setup, access held until pready, then an idle edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk_word(n, e, rd);
    endtask
    initial begin
        {psel, penable, pwrite, aux_in, monitor_present, echo_en} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        stroke_len = 8'h32;
        presetn = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc("ctrl", OFS_CTRL, 32'h308);
        rdc("factor", OFS_FACTOR, 32'h64);
        rdc("batch", OFS_BATCH, 32'h1);
        rdc("rate", OFS_RATE, 32'h64);
        rdc("flow", OFS_FLOW, 32'h0);
        apb(1'b0, 8'h34, 32'h0);
        chk_bit("slverr", 1'b1, err);
        chk_word("unmapped", 32'h0, rd);
        $display("test reset done");
        wr(OFS_RATE, 32'h1);
        foreach (tbl[i]) begin
            wr(OFS_CTRL, 32'h8);
            wr(OFS_CTRL, 32'hA);
            rdc("factor", OFS_FACTOR, 32'h64);
            rdc("pending", OFS_PENDING, 32'h0);
            wr(OFS_FACTOR, tbl[i][0]);
            base = strokes;
            repeat (tbl[i][1]) begin
                u_contact_source.pulse();
                repeat (70) @(posedge pclk);
            end
            chk_word("strokes", tbl[i][2], strokes - base);
        end
        wr(OFS_FACTOR, 32'h0);
        wr(OFS_FACTOR, 32'd10000);
        rdc("factor", OFS_FACTOR, 32'h1);
        $display("test contact done");
        wr(OFS_CTRL, 32'hB);
        wr(OFS_BATCH, 32'h3);
        wr(OFS_BATCH, 32'h0);
        rdc("batch", OFS_BATCH, 32'h3);
        base = strokes;
        wr(OFS_CMD, 32'h1);
        repeat (40) @(posedge pclk);
        chk_word("batch key", 32'h3, strokes - base);
        u_contact_source.pulse();
        repeat (40) @(posedge pclk);
        chk_word("batch pulse", 32'h6, strokes - base);
        wr(OFS_CMD, 32'h2);
        rdc("qty", OFS_CTRL, 32'h1B);
        aux_in <= 1'b1;
        repeat (10) @(posedge pclk);
        chk_bit("aux", 1'b1, aux_ind);
        aux_in <= 1'b0;
        $display("test batch done");
        wr(OFS_CTRL, 32'h0);
        repeat (5) @(posedge pclk);
        base = strokes;
        wr(OFS_CMD, 32'h4);
        wr(OFS_CTRL, 32'h8); // run set, so the stop after calibration is seen
        repeat (40) @(posedge pclk);
        wr(OFS_CMD, 32'h8);
        repeat (5) @(posedge pclk);
        rdc("calcnt", OFS_CALCNT, strokes - base);
        chk_bit("cal ran", 1'b1, (strokes - base) > 10);
        rdc("total", OFS_TOTAL, 32'h0);
        rdc("volume", OFS_VOLUME, 32'h0);
        rdc("stopped", OFS_CTRL, 32'h0);
        stroke_len <= 8'h3C;
        repeat (5) @(posedge pclk);
        chk_bit("warn", 1'b0, warn_lamp);
        stroke_len <= 8'h3D;
        repeat (5) @(posedge pclk);
        chk_bit("warn", 1'b1, warn_lamp);
        chk_bit("flash", 1'b1, calib_flash);
        $display("test calib done");
        // memory on, run off: owed strokes pile up until the memory overflows
        wr(OFS_CTRL, 32'h6);
        wr(OFS_FACTOR, 32'd9999);
        repeat (660) u_contact_source.pulse();
        chk_bit("fault", 1'b1, fault_out);
        chk_bit("mem", 1'b1, mem_ind);
        rdc("status", OFS_STATUS, 32'hD);
        wr(OFS_CTRL, 32'hE);
        base = strokes;
        repeat (20) @(posedge pclk);
        chk_word("fault quiet", 32'h0, strokes - base);
        wr(OFS_CMD, 32'h10);
        wr(OFS_CTRL, 32'h0);
        repeat (2) @(posedge pclk);
        chk_bit("fault ack", 1'b0, fault_out);
        $display("test fault done");
        // slower rate: the monitor answer needs about five cycles to come back
        wr(OFS_RATE, 32'h8);
        monitor_present <= 1'b1;
        echo_en <= 1'b1;
        repeat (3) @(posedge pclk); // monitor detect passes the synchroniser first
        wr(OFS_FLOW, 32'h2);
        rdc("flow", OFS_FLOW, 32'h2);
        wr(OFS_CTRL, 32'h8);
        repeat (60) @(posedge pclk);
        rdc("running", OFS_CTRL, 32'h8);
        echo_en <= 1'b0;
        repeat (100) @(posedge pclk);
        rdc("flow stop", OFS_CTRL, 32'h0);
        $display("test flow done");
        test_done();
    end
endmodule
`default_nettype wire
